/* dstc_controller.sv */
`timescale 1ns/10ps
`include "dstc_map.svh"
// Notes on behaviour
// - Precharge field sets minimum row-idle cycles
// - Row-to-column delay: one, two or three cycles
// - Write-to-precharge delay before auto-precharge, next activate
// - Bank-active: write to precharge delay; synchronous only
// - Asynchronous refresh row width two to five
// - No activate for row-active time after refresh
// - Synchronous row-active 3,4,6,9; wait after self-exit
// - Burst bit enables page mode for asynchronous memory
// - Page bursts depend on bus width, transfer kind
// - Synchronous accesses always burst
// - Bank-active off: close row, auto-precharge
// - Bank-active on, asynchronous: row strobe stays asserted
// - Bank-active synchronous only area 3
// - Column address width codes; top bit reserved
// - Synchronous organisation codes; 110 reserved
// - Width bit picks 16 or 32 bit bus
// - Refresh enable bit, off after reset
// - Interval tick triggers one refresh
// - Refresh waits for running access to finish
// - Self-refresh entry waits for access end
// - Interval ticks ignored during self-refresh
module dstc_controller
   import dstc_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Memory type and interval timer
   input  wire logic        memIsSdram,
   input  wire logic        refreshTick,
   // Access request
   input  wire logic        accReq,
   input  wire logic        accWrite,
   input  wire logic        accArea3,
   input  wire logic        accSameRow,
   input  wire logic [1:0]  accKind,
   output logic             accAck,
   output logic             accBurst,
   // Memory side
   output dstc_cmd_t        memCmd,
   output logic             rowStrobeOn,
   output logic             colStrobeOn,
   output logic             busWide,
   output logic [3:0]       colAddrBits,
   output logic [2:0]       sdramOrg,
   output logic             selfRefreshOn
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [15:0]  ctrl_reg;
   dstc_state_t  state_reg;
   dstc_state_t  stateNext;
   dstc_cmd_t    cmd_reg;
   dstc_cmd_t    cmdNext;
   logic         rowStrobe_reg;
   logic         rowNext;
   logic         colStrobe_reg;
   logic         colNext;
   logic         rowOpen_reg;
   logic         openNext;
   logic         explicitPre_reg;
   logic         explicitNext;
   logic         refPend_reg;
   logic         ack_reg;
   logic         ackNext;
   logic         burst_reg;
   logic         accWrite_reg;
   logic         accArea3_reg;
   logic         takeAcc;
   logic         refDone;
   logic         tmrLoad;
   logic [3:0]   tmrValue;
   logic         tmrDone;
   logic         wrLoad;
   logic         wrDone;
   logic [3:0]   prechargeCycles;
   logic [3:0]   rcdCycles;
   logic [3:0]   trwlCycles;
   logic [3:0]   trasCycles;
   logic         muxReserved;
   logic         orgClash;
   logic         selfWanted;
   logic         keepOpen;
   logic         refreshOn;
   logic [31:0]  prdata_reg;
   logic         pslverr_reg;
   logic         apbSetup;
   logic         apbWrite;
   logic [31:0]  statusWord;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Asynchronous page bursts only for transfers that span several bus beats; synchronous always bursts
   function automatic logic burstEligible(input logic       sdram,
                                          input logic       burstOn,
                                          input logic       wide,
                                          input logic [1:0] kind);
      logic multi;
      multi = (kind == KIND_CACHE_FILL) || (kind == KIND_DMA16) ||
              (!wide && (kind == KIND_LONGWORD));
      if (sdram) begin
         burstEligible = 1'b1;
      end else begin
         burstEligible = burstOn && multi;
      end
   endfunction

   // ----------------------------------------
   // Field decode and timers
   // ----------------------------------------
   dstc_field_decode u_decode (
      .ctrl            (ctrl_reg),
      .memIsSdram      (memIsSdram),
      .prechargeCycles (prechargeCycles),
      .rcdCycles       (rcdCycles),
      .trwlCycles      (trwlCycles),
      .trasCycles      (trasCycles),
      .colAddrBits     (colAddrBits),
      .sdramOrg        (sdramOrg),
      .muxReserved     (muxReserved),
      .orgClash        (orgClash)
   );

   dstc_wait_timer u_phase_timer (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .load      (tmrLoad),
      .loadValue (tmrValue),
      .done      (tmrDone)
   );

   // Separate timer so write recovery overlaps the bus handover
   dstc_wait_timer u_write_timer (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .load      (wrLoad),
      .loadValue (trwlCycles - 4'h1),
      .done      (wrDone)
   );

   assign refreshOn  = ctrl_reg[`DSTC_BIT_REF_ON];
   assign selfWanted = refreshOn && ctrl_reg[`DSTC_BIT_REF_KIND];
   assign keepOpen   = ctrl_reg[`DSTC_BIT_KEEP_OPEN] &&
                       (!memIsSdram || accArea3_reg);

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   assign apbSetup = psel && !penable;
   assign apbWrite = psel && penable && pwrite;
   assign pready   = 1'b1;

   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[`DSTC_STAT_STATE_LSB +: 4] = state_reg;
      statusWord[`DSTC_STAT_ROW_OPEN]  = rowOpen_reg;
      statusWord[`DSTC_STAT_REF_PEND]  = refPend_reg;
      statusWord[`DSTC_STAT_SELF]      = (state_reg == ST_SELF);
      statusWord[`DSTC_STAT_ORG_CLASH] = orgClash;
      statusWord[`DSTC_STAT_MUX_RSVD]  = muxReserved;
   end

   // Read data captured in setup so a zero-wait access phase suffices
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (apbSetup) begin
         if (paddr == `DSTC_OFS_CTRL) begin
            prdata_reg  <= {16'h0000, ctrl_reg};
            pslverr_reg <= 1'b0;
         end else if (paddr == `DSTC_OFS_STAT) begin
            prdata_reg  <= statusWord;
            pslverr_reg <= 1'b0;
         end else begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b1;
         end
      end
   end

   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= `DSTC_CTRL_RESET;
      end else if (apbWrite && (paddr == `DSTC_OFS_CTRL)) begin
         // Timing fields are live; rewriting other values mid-traffic is unsafe
         if (pstrb[0]) begin
            ctrl_reg[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            ctrl_reg[15:8] <= pwdata[15:8];
         end
      end
   end

   // ----------------------------------------
   // Refresh request
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         refPend_reg <= 1'b0;
      end else if (refreshTick && refreshOn && !selfWanted &&
                   (state_reg != ST_SELF)) begin
         refPend_reg <= 1'b1;
      end else if (refDone || !refreshOn) begin
         refPend_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      stateNext    = state_reg;
      cmdNext      = CMD_NOP;
      rowNext      = rowStrobe_reg;
      colNext      = 1'b0;
      openNext     = rowOpen_reg;
      explicitNext = explicitPre_reg;
      ackNext      = 1'b0;
      takeAcc      = 1'b0;
      refDone      = 1'b0;
      tmrLoad      = 1'b0;
      tmrValue     = 4'h0;
      wrLoad       = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // Only reached between accesses, so refresh never splits one
            if (selfWanted) begin
               if (rowOpen_reg) begin
                  explicitNext = 1'b1;
                  stateNext    = ST_PRECHARGE;
               end else begin
                  cmdNext   = memIsSdram ? CMD_SELF_ENTER : CMD_NOP;
                  rowNext   = !memIsSdram;
                  colNext   = !memIsSdram;
                  stateNext = ST_SELF;
               end
            end else if (refPend_reg) begin
               if (rowOpen_reg) begin
                  explicitNext = 1'b1;
                  stateNext    = ST_PRECHARGE;
               end else begin
                  cmdNext   = memIsSdram ? CMD_AUTO_REFRESH : CMD_NOP;
                  rowNext   = !memIsSdram;
                  colNext   = !memIsSdram;
                  refDone   = 1'b1;
                  tmrLoad   = 1'b1;
                  tmrValue  = trasCycles - 4'h1;
                  stateNext = ST_REFRESH;
               end
            end else if (accReq) begin
               if (rowOpen_reg && accSameRow) begin
                  takeAcc   = 1'b1;
                  tmrLoad   = 1'b1;
                  tmrValue  = 4'h0;
                  stateNext = ST_ROW_WAIT;
               end else if (rowOpen_reg) begin
                  explicitNext = 1'b1;
                  stateNext    = ST_PRECHARGE;
               end else begin
                  takeAcc   = 1'b1;
                  cmdNext   = memIsSdram ? CMD_BANK_ACTIVATE : CMD_NOP;
                  rowNext   = !memIsSdram;
                  openNext  = 1'b1;
                  tmrLoad   = 1'b1;
                  tmrValue  = rcdCycles - 4'h1;
                  stateNext = ST_ROW_WAIT;
               end
            end
         end
         ST_ROW_WAIT: begin
            if (tmrDone) begin
               if (!memIsSdram) begin
                  cmdNext = CMD_NOP;
               end else if (accWrite_reg) begin
                  cmdNext = keepOpen ? CMD_WRITE : CMD_WRITE_AUTOPRE;
               end else begin
                  cmdNext = keepOpen ? CMD_READ : CMD_READ_AUTOPRE;
               end
               colNext   = !memIsSdram;
               ackNext   = 1'b1;
               wrLoad    = memIsSdram && accWrite_reg;
               stateNext = ST_COLUMN;
            end
         end
         ST_COLUMN: begin
            if (keepOpen) begin
               stateNext = ST_IDLE;
            end else begin
               explicitNext = 1'b0;
               stateNext    = ST_PRECHARGE;
            end
         end
         ST_PRECHARGE: begin
            if (wrDone) begin
               cmdNext   = (memIsSdram && explicitPre_reg) ? CMD_PRECHARGE : CMD_NOP;
               rowNext   = 1'b0;
               openNext  = 1'b0;
               tmrLoad   = 1'b1;
               tmrValue  = prechargeCycles - 4'h1;
               stateNext = ST_PRE_WAIT;
            end
         end
         ST_PRE_WAIT: begin
            if (tmrDone) begin
               stateNext = ST_IDLE;
            end
         end
         ST_REFRESH: begin
            colNext = !memIsSdram;
            if (tmrDone) begin
               rowNext = 1'b0;
               colNext = 1'b0;
               if (memIsSdram) begin
                  stateNext = ST_IDLE;
               end else begin
                  tmrLoad   = 1'b1;
                  tmrValue  = prechargeCycles - 4'h1;
                  stateNext = ST_PRE_WAIT;
               end
            end
         end
         ST_SELF: begin
            colNext = !memIsSdram;
            if (!selfWanted) begin
               cmdNext   = memIsSdram ? CMD_SELF_EXIT : CMD_NOP;
               rowNext   = 1'b0;
               colNext   = 1'b0;
               tmrLoad   = 1'b1;
               tmrValue  = trasCycles - 4'h1;
               stateNext = ST_SELF_EXIT;
            end
         end
         ST_SELF_EXIT: begin
            if (tmrDone) begin
               stateNext = ST_IDLE;
            end
         end
         default: begin
            stateNext = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg       <= ST_IDLE;
         explicitPre_reg <= 1'b0;
      end else begin
         state_reg       <= stateNext;
         explicitPre_reg <= explicitNext;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_reg       <= CMD_NOP;
         rowStrobe_reg <= 1'b0;
         colStrobe_reg <= 1'b0;
         rowOpen_reg   <= 1'b0;
         ack_reg       <= 1'b0;
      end else begin
         cmd_reg       <= cmdNext;
         rowStrobe_reg <= rowNext;
         colStrobe_reg <= colNext;
         rowOpen_reg   <= openNext;
         ack_reg       <= ackNext;
      end
   end

   // Access attributes latched so a changing request cannot skew the cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         accWrite_reg <= 1'b0;
         accArea3_reg <= 1'b0;
         burst_reg    <= 1'b0;
      end else if (takeAcc) begin
         accWrite_reg <= accWrite;
         accArea3_reg <= accArea3;
         burst_reg    <= burstEligible(memIsSdram, ctrl_reg[`DSTC_BIT_BURST],
                                       ctrl_reg[`DSTC_BIT_WIDTH], accKind);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign memCmd        = cmd_reg;
   assign rowStrobeOn   = rowStrobe_reg;
   assign colStrobeOn   = colStrobe_reg;
   assign accAck        = ack_reg;
   assign accBurst      = burst_reg;
   assign busWide       = ctrl_reg[`DSTC_BIT_WIDTH];
   assign selfRefreshOn = (state_reg == ST_SELF);

endmodule

/* dstc_map.svh */
`ifndef DSTC_MAP_SVH
`define DSTC_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DSTC_OFS_CTRL        12'h000
`define DSTC_OFS_STAT        12'h004

// ----------------------------------------
// Control register field positions
// ----------------------------------------
`define DSTC_BIT_TRP_LO      15
`define DSTC_BIT_RCD_LO      14
`define DSTC_BIT_TRWL_LO     13
`define DSTC_BIT_TRAS_HI     12
`define DSTC_BIT_TRAS_LO     11
`define DSTC_BIT_BURST       10
`define DSTC_BIT_KEEP_OPEN   9
`define DSTC_BIT_TRWL_HI     8
`define DSTC_BIT_ADDRESS_MUX_SELECT_2        7
`define DSTC_BIT_WIDTH       6
`define DSTC_BIT_ADDRESS_MUX_SELECT_1        5
`define DSTC_BIT_ADDRESS_MUX_SELECT_0        4
`define DSTC_BIT_REF_ON      3
`define DSTC_BIT_REF_KIND    2
`define DSTC_BIT_TRP_HI      1
`define DSTC_BIT_RCD_HI      0
`define DSTC_CTRL_RESET      16'h0000

// ----------------------------------------
// Status register field positions
// ----------------------------------------
`define DSTC_STAT_STATE_LSB  0
`define DSTC_STAT_ROW_OPEN   4
`define DSTC_STAT_REF_PEND   5
`define DSTC_STAT_SELF       6
`define DSTC_STAT_ORG_CLASH  7
`define DSTC_STAT_MUX_RSVD   8

// ----------------------------------------
// Timing figures in cycles; column address base in bits
// ----------------------------------------
`define DSTC_CYC_ONE         4'h1
`define DSTC_CYC_TWO         4'h2
`define DSTC_CYC_THREE       4'h3
`define DSTC_CYC_FOUR        4'h4
`define DSTC_CYC_SIX         4'h6
`define DSTC_CYC_NINE        4'h9
`define DSTC_COL_BITS_BASE   4'h8

`endif

/* dstc_pkg.sv */
package dstc_pkg;

   // ----------------------------------------
   // Controller states
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_ROW_WAIT  = 4'b0001,
      ST_COLUMN    = 4'b0010,
      ST_PRECHARGE = 4'b0011,
      ST_PRE_WAIT  = 4'b0100,
      ST_REFRESH   = 4'b0101,
      ST_SELF      = 4'b0110,
      ST_SELF_EXIT = 4'b0111
   } dstc_state_t;

   // ----------------------------------------
   // Synchronous memory commands
   // ----------------------------------------
   typedef enum logic [3:0] {
      CMD_NOP           = 4'b0000,
      CMD_BANK_ACTIVATE = 4'b0001,
      CMD_READ          = 4'b0010,
      CMD_READ_AUTOPRE  = 4'b0011,
      CMD_WRITE         = 4'b0100,
      CMD_WRITE_AUTOPRE = 4'b0101,
      CMD_PRECHARGE     = 4'b0110,
      CMD_AUTO_REFRESH  = 4'b0111,
      CMD_SELF_ENTER    = 4'b1000,
      CMD_SELF_EXIT     = 4'b1001
   } dstc_cmd_t;

   // ----------------------------------------
   // Transfer kinds
   // ----------------------------------------
   typedef enum logic [1:0] {
      KIND_SINGLE     = 2'b00,
      KIND_LONGWORD   = 2'b01,
      KIND_CACHE_FILL = 2'b10,
      KIND_DMA16      = 2'b11
   } dstc_kind_t;

endpackage

/* dstc_wait_timer.sv */
`timescale 1ns/10ps
module dstc_wait_timer
   import dstc_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Load and status
   input  wire logic       load,
   input  wire logic [3:0] loadValue,
   output logic            done
);

   logic [3:0] cnt_reg;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 4'h0;
      end else if (load) begin
         cnt_reg <= loadValue;
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end

   assign done = (cnt_reg == 4'h0);

endmodule

/* dstc_field_decode.sv */
`timescale 1ns/10ps
`include "dstc_map.svh"
module dstc_field_decode
   import dstc_pkg::*;
(
   // Configuration
   input  wire logic [15:0] ctrl,
   input  wire logic        memIsSdram,
   // Decoded timing
   output logic [3:0]       prechargeCycles,
   output logic [3:0]       rcdCycles,
   output logic [3:0]       trwlCycles,
   output logic [3:0]       trasCycles,
   // Decoded organisation
   output logic [3:0]       colAddrBits,
   output logic [2:0]       sdramOrg,
   output logic             muxReserved,
   output logic             orgClash
);

   // Reserved code saturates to the longest legal delay
   function automatic logic [3:0] code3(input logic [1:0] c);
      case (c)
         2'b00:   code3 = `DSTC_CYC_ONE;
         2'b01:   code3 = `DSTC_CYC_TWO;
         default: code3 = `DSTC_CYC_THREE;
      endcase
   endfunction

   logic [1:0] trasCode;
   logic [2:0] amx;

   assign trasCode = {ctrl[`DSTC_BIT_TRAS_HI], ctrl[`DSTC_BIT_TRAS_LO]};
   assign amx      = {ctrl[`DSTC_BIT_ADDRESS_MUX_SELECT_2], ctrl[`DSTC_BIT_ADDRESS_MUX_SELECT_1], ctrl[`DSTC_BIT_ADDRESS_MUX_SELECT_0]};

   assign prechargeCycles = ctrl[`DSTC_BIT_TRP_HI] ? `DSTC_CYC_TWO :
                            (ctrl[`DSTC_BIT_TRP_LO] ? `DSTC_CYC_TWO : `DSTC_CYC_ONE);
   assign rcdCycles  = code3({ctrl[`DSTC_BIT_RCD_HI], ctrl[`DSTC_BIT_RCD_LO]});
   assign trwlCycles = code3({ctrl[`DSTC_BIT_TRWL_HI], ctrl[`DSTC_BIT_TRWL_LO]});

   always_comb begin
      if (memIsSdram) begin
         case (trasCode)
            2'b00:   trasCycles = `DSTC_CYC_THREE;
            2'b01:   trasCycles = `DSTC_CYC_FOUR;
            2'b10:   trasCycles = `DSTC_CYC_SIX;
            default: trasCycles = `DSTC_CYC_NINE;
         endcase
      end else begin
         trasCycles = {2'b00, trasCode} + `DSTC_CYC_TWO;
      end
   end

   assign colAddrBits = `DSTC_COL_BITS_BASE + {2'b00, amx[1:0]};
   assign sdramOrg    = amx;
   assign muxReserved = memIsSdram ? (amx == 3'b110) : amx[2];
   // Byte and nibble wide parts need the 32-bit bus
   assign orgClash    = memIsSdram && !ctrl[`DSTC_BIT_WIDTH] &&
                        ((amx == 3'b001) || (amx == 3'b010) || (amx == 3'b101));

endmodule

/* dstc_checker_props.sv */
`timescale 1ns/10ps
module dstc_checker
   import dstc_pkg::*;
(
   // Clock, reset, register bus
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Access and memory side
   input wire logic        memIsSdram,
   input wire logic        accAck,
   input wire logic        accArea3,
   input wire logic        accBurst,
   input dstc_cmd_t        memCmd,
   input wire logic        busWide,
   input wire logic [3:0]  colAddrBits,
   input wire logic [2:0]  sdramOrg,
   input wire logic        selfRefreshOn
);
   logic [15:0] ctrl_reg;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Shadow copy; the bench always writes both lanes
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) ctrl_reg <= 16'h0000;
      else if (psel && penable && pwrite && paddr == 12'h000) ctrl_reg <= pwdata[15:0];
   end
   sequence act_s; memCmd == CMD_BANK_ACTIVATE; endsequence
   sequence exit_s; memCmd == CMD_SELF_EXIT; endsequence
   bus_width_a: assert property (busWide == ctrl_reg[6])
      else $error("bus width differs from control");
   col_bits_a: assert property (!ctrl_reg[7] |-> colAddrBits == 4'h8 + {2'h0, ctrl_reg[5:4]})
      else $error("column bits wrong");
   org_code_a: assert property (sdramOrg == {ctrl_reg[7], ctrl_reg[5:4]})
      else $error("organisation code wrong");
   sync_burst_a: assert property (accAck && memIsSdram |-> accBurst)
      else $error("sync access without burst");
   auto_pre_a: assert property (
      accAck && memIsSdram && (!ctrl_reg[9] || !accArea3)
      |-> memCmd inside {CMD_READ_AUTOPRE, CMD_WRITE_AUTOPRE})
      else $error("auto precharge missing");
   rcd_one_a: assert property (act_s ##0 (!ctrl_reg[0] && !ctrl_reg[14]) |=> accAck)
      else $error("column command not one cycle after activate");
   rcd_three_a: assert property (
      act_s ##0 (ctrl_reg[0] && !ctrl_reg[14])
      |=> !accAck [*2] ##1 accAck)
      else $error("column command not three cycles after activate");
   refresh_gap_a: assert property (
      memCmd == CMD_AUTO_REFRESH && ctrl_reg[12:11] == 2'h0
      |=> (memCmd != CMD_BANK_ACTIVATE) [*2])
      else $error("activate too soon after refresh");
   self_quiet_a: assert property (selfRefreshOn |-> memCmd != CMD_AUTO_REFRESH)
      else $error("refresh issued in self refresh");
   exit_wait_a: assert property (exit_s |=> (memCmd == CMD_NOP) [*3])
      else $error("command too soon after self exit");
endmodule

bind dstc_controller dstc_checker i_chk (.*);

/* dstc_mem_model.sv */
`timescale 1ns/10ps
module dstc_mem_model
   import dstc_pkg::*;
(
   // Clock and command bus
   input wire logic sys_clk,
   input dstc_cmd_t memCmd,
   // Refreshes seen
   output int       nRef
);
   // Counting only: the part sends nothing back to the controller
   initial nRef = 0;
   always @(posedge sys_clk) begin
      if (memCmd == CMD_AUTO_REFRESH) nRef <= nRef + 1;
   end
endmodule

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
   import dstc_pkg::*;
   logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hF, colAddrBits;
   logic [1:0] accKind = 2'h0;
   logic [2:0] sdramOrg;
   logic memIsSdram = 1'b1, refreshTick = 1'b0, accReq = 1'b0, accWrite = 1'b0;
   logic accArea3 = 1'b0, accSameRow = 1'b0, pready, pslverr, accAck, accBurst;
   logic rowStrobeOn, colStrobeOn, busWide, selfRefreshOn;
   dstc_cmd_t memCmd;
   int errors = 0, n_tests = 0, nRef;
   always #20 sys_clk = ~sys_clk;
   dstc_controller i_dut (.*);
   dstc_mem_model i_mem (.sys_clk(sys_clk), .memCmd(memCmd), .nRef(nRef));
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      {r, e} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
      if (n == 20) begin errors++; end_of_test; end
   endtask
   task automatic wr(input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, 12'h000, d, r, e);
      tick(1);
   endtask
   task automatic acc(input logic w, output logic [3:0] c, output int lat);
      {accReq, accWrite} <= {1'b1, w};
      for (lat = 0; lat < 30; lat++) begin
         @(posedge sys_clk); #1;
         if (accAck === 1'b1) break;
      end
      c = memIsSdram ? memCmd : {3'h0, colStrobeOn};
      @(posedge sys_clk);
      accReq <= 1'b0;
      if (lat == 30) begin errors++; end_of_test; end
   endtask
   task automatic pulse;
      @(posedge sys_clk); refreshTick <= 1'b1;
      @(posedge sys_clk); refreshTick <= 1'b0;
      tick(8);
   endtask
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      apb(1'b0, 12'h000, 32'h0, r, e); chk("control reset", r, 32'h0);
      wr(32'h70); apb(1'b0, 12'h000, 32'h0, r, e); chk("control readback", r, 32'h70);
      chk("column bits", colAddrBits, 32'hB);
      chk("bus wide", busWide, 32'h1);
      wr(32'hB0); chk("organisation", sdramOrg, 32'h7);
      apb(1'b0, 12'h008, 32'h0, r, e); chk("unmapped error", e, 32'h1);
      chk("unmapped data", r, 32'h0);
      wr(32'h0); $display("registers done");
   endtask
   task automatic t_access;
      logic [3:0] c;
      int lat;
      for (int i = 0; i < 2; i++) begin
         wr(i ? 32'h1 : 32'h0); tick(8); acc(i[0], c, lat);
         chk("activate to column", lat, i ? 32'h3 : 32'h1);
         chk("column command", c, i ? CMD_WRITE_AUTOPRE : CMD_READ_AUTOPRE);
         chk("burst", accBurst, 32'h1);
      end
      $display("access done");
   endtask
   task automatic t_refresh;
      int n = nRef;
      wr(32'h8); pulse; chk("auto refresh", nRef, n + 1);
      wr(32'hC); tick(4); chk("self entry", selfRefreshOn, 32'h1);
      n = nRef; pulse; chk("tick in self", nRef, n);
      wr(32'h8); tick(8); chk("self exit", selfRefreshOn, 32'h0);
      wr(32'h0); n = nRef; pulse; chk("refresh off", nRef, n);
      $display("refresh done");
   endtask
   task automatic t_open;
      logic [3:0] c;
      int lat;
      memIsSdram <= 1'b0; wr(32'h200); tick(4); acc(1'b0, c, lat); tick(3);
      chk("row kept open", rowStrobeOn, 32'h1);
      chk("column strobe", c, 32'h1);
      chk("no page burst", accBurst, 32'h0);
      accKind <= 2'h2; wr(32'h600); acc(1'b0, c, lat);
      chk("page burst", accBurst, 32'h1);
      $display("open row done");
   endtask
   initial begin
      tick(6); nrst <= 1'b1;
      t_regs; t_access; t_refresh; t_open;
      end_of_test;
   end
endmodule
